// ### rtl/ssf_defines.svh
// register offsets, field positions, reset values and codes of the sample fifo
`ifndef SSF_DEFINES_SVH
`define SSF_DEFINES_SVH
`define SSF_ADDR_FLAGS 8'h00
`define SSF_ADDR_MASK 8'h01
`define SSF_ADDR_WR_IDX 8'h02
`define SSF_ADDR_LOST 8'h03
`define SSF_ADDR_RD_IDX 8'h04
`define SSF_ADDR_DATA 8'h05
`define SSF_ADDR_LAST 8'hFF
`define SSF_BIT_NEARLY_FULL 7
`define SSF_BIT_TEMP_DONE 6
`define SSF_BIT_PULSE 5
`define SSF_BIT_OXY 4
`define SSF_BIT_SUPPLY_OK 0
`define SSF_MASK_BITS 8'hF0
`define SSF_FLAG_BITS 8'hF1
`define SSF_REG_RESET 8'h00
`define SSF_IDX_RESET 4'h0
`define SSF_LOST_MAX 4'hF
`define SSF_LAST_BYTE 2'h3
`define SSF_MODE_OFF 3'h0
`endif

// ### rtl/ssf_pkg.sv
// types shared by the sample fifo design
package ssf_pkg;
  typedef enum logic [2:0]
  {
    SSF_MODE_PULSE = 3'h2,
    SSF_MODE_OXY = 3'h3
  } ssf_mode_t;
  typedef logic [3:0] ssf_idx_t;
  typedef logic [7:0] ssf_byte_t;
endpackage : ssf_pkg

// ### rtl/ssf_top.sv
// sample fifo, lost-sample counter, register pointer and interrupt flags
// Function
// - five interrupt sources; any set enabled flag pulls the pin low
// - reading status or data port clears all flags and releases the pin
// - nearly-full flag bit 7 set when write index is read index minus one
// - when full, samples are dropped and lost count increments, saturating
// - lost count returns to zero whenever the read index advances
// - temperature-done flag bit 6 set when a conversion finishes
// - pulse-sample flag bit 5 set per sample, cleared by data port read
// - oxy-sample flag bit 4 set per sample in oxy mode only
// - supply-ok flag bit 0 set when supply rises above lockout
// - supply-ok always drives the pin; other four sources are maskable
// - brownout resets every register but the sample memory, so every enable returns to disabled
// - masked sources still set their status bit but do not drive the pin
// - write index advances per stored sample; host may write it whenever the mode code is not 000
// - read index advances per popped sample; host may rewrite to re-read
// - circular buffer of 16 samples, 4 bytes each
// - data port reads keep the address; read index advances every 4 bytes
// - other reads auto-increment the address, stopping past 0xFF
// - sample words are left-justified with the msb at bit 15
// - in pulse-only mode bytes 3 and 4 of each sample read as zero
// - byte order is IR high, IR low, red high, red low
// - mode code 010 is pulse-only, 011 is oxy; others are idle
// - power-save clears all flags while registers stay accessible
`include "ssf_defines.svh"

module ssf_top
  import ssf_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4
)
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [2:0] MODE,
  input wire logic POWER_SAVE,
  input wire logic [1:0] ADC_RES,
  input wire logic SAMPLE_VALID,
  input wire logic [15:0] SAMPLE_IR,
  input wire logic [15:0] SAMPLE_RED,
  input wire logic TEMP_DONE,
  input wire logic SUPPLY_OK,
  input wire logic ADDR_LOAD,
  input wire logic [7:0] ADDR_IN,
  input wire logic REG_WR,
  input wire logic [7:0] WR_DATA,
  input wire logic REG_RD,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic INT_N_O,
  output logic INT_N_OE
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // raw words arrive right-justified at the current adc resolution
  function automatic logic [15:0] justify(input logic [15:0] w,
                                          input logic [1:0] res);
    unique case (res)
      2'h0: justify = {w[12:0], 3'h0};
      2'h1: justify = {w[13:0], 2'h0};
      2'h2: justify = {w[14:0], 1'h0};
      2'h3: justify = w;
    endcase
  endfunction : justify

  function automatic logic is_addr(input ssf_byte_t ptr, input logic over,
                                   input ssf_byte_t want);
    is_addr = !over && (ptr == want);
  endfunction : is_addr

  // ----------------------------------------------------------------
  // register pointer
  // ----------------------------------------------------------------
  ssf_byte_t reg_ptr;
  logic ptr_over;
  logic [7:0] irq_flags;
  logic [7:0] irq_mask;
  ssf_idx_t sample_write_index;
  ssf_idx_t lost_sample_count;
  ssf_idx_t sample_read_index;
  logic [1:0] byte_sel;
  logic buf_full;
  logic [31:0] sample_mem [DEPTH];

  wire logic active_mode = (MODE == SSF_MODE_PULSE)
                           || (MODE == SSF_MODE_OXY);
  wire logic acc = REG_WR || REG_RD;
  wire logic rd_data = REG_RD && is_addr(reg_ptr, ptr_over, `SSF_ADDR_DATA);
  wire logic rd_flags = REG_RD && is_addr(reg_ptr, ptr_over, `SSF_ADDR_FLAGS);
  wire logic wr_mask = REG_WR && is_addr(reg_ptr, ptr_over, `SSF_ADDR_MASK);
  wire logic wr_wi = REG_WR && is_addr(reg_ptr, ptr_over, `SSF_ADDR_WR_IDX)
                     && (MODE != `SSF_MODE_OFF);
  wire logic wr_lost = REG_WR && is_addr(reg_ptr, ptr_over, `SSF_ADDR_LOST);
  wire logic wr_ri = REG_WR && is_addr(reg_ptr, ptr_over, `SSF_ADDR_RD_IDX);
  wire logic sample_in = SAMPLE_VALID && active_mode;
  wire logic store = sample_in && !buf_full;
  wire logic pop = rd_data && (byte_sel == `SSF_LAST_BYTE);
  wire ssf_idx_t wi_next = sample_write_index + ssf_idx_t'(1);
  wire ssf_idx_t wi_next2 = sample_write_index + ssf_idx_t'(2);

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      reg_ptr <= `SSF_REG_RESET;
      ptr_over <= 1'b0;
    end
    else if (ADDR_LOAD)
    begin
      reg_ptr <= ADDR_IN;
      ptr_over <= 1'b0;
    end
    else if (acc && reg_ptr != `SSF_ADDR_DATA)
    begin
      // no wrap past the top: further bytes are meaningless
      if (reg_ptr == `SSF_ADDR_LAST)
        ptr_over <= 1'b1;
      else
        reg_ptr <= reg_ptr + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // sample storage and indices
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (store)
      sample_mem[sample_write_index] <= {justify(SAMPLE_IR, ADC_RES),
        justify(SAMPLE_RED, ADC_RES)};
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      sample_write_index <= `SSF_IDX_RESET;
    else if (wr_wi)
      sample_write_index <= WR_DATA[3:0];
    else if (store)
      sample_write_index <= wi_next;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      sample_read_index <= `SSF_IDX_RESET;
    else if (wr_ri)
      sample_read_index <= WR_DATA[3:0];
    else if (pop)
      sample_read_index <= sample_read_index + ssf_idx_t'(1);
  end

  // a rewritten read index restarts at the first byte of a sample
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET || wr_ri)
      byte_sel <= 2'h0;
    else if (rd_data)
      byte_sel <= byte_sel + 2'h1;
  end

  // equal indices are ambiguous, so fullness is remembered explicitly
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET || wr_wi || wr_ri)
      buf_full <= 1'b0;
    else if (store && !pop && wi_next == sample_read_index)
      buf_full <= 1'b1;
    else if (pop && !store)
      buf_full <= 1'b0;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      lost_sample_count <= `SSF_IDX_RESET;
    else if (wr_lost)
      lost_sample_count <= WR_DATA[3:0];
    else if (pop)
      lost_sample_count <= `SSF_IDX_RESET;
    else if (sample_in && buf_full && lost_sample_count != `SSF_LOST_MAX)
      lost_sample_count <= lost_sample_count + ssf_idx_t'(1);
  end

  // ----------------------------------------------------------------
  // interrupt flags and mask
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[`SSF_BIT_NEARLY_FULL] = store
      && wi_next2 == sample_read_index;
    flag_set[`SSF_BIT_TEMP_DONE] = TEMP_DONE;
    flag_set[`SSF_BIT_PULSE] = sample_in;
    flag_set[`SSF_BIT_OXY] = sample_in && MODE == SSF_MODE_OXY;
    flag_set[`SSF_BIT_SUPPLY_OK] = SUPPLY_OK;
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET || POWER_SAVE)
      irq_flags <= `SSF_REG_RESET;
    else if (rd_flags || rd_data)
      irq_flags <= flag_set;
    else
      irq_flags <= irq_flags | flag_set;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      irq_mask <= `SSF_REG_RESET;
    else if (wr_mask)
      irq_mask <= WR_DATA & `SSF_MASK_BITS;
  end

  wire logic irq_active = |(irq_flags & irq_mask)
                          || irq_flags[`SSF_BIT_SUPPLY_OK];
  assign INT_N_O = 1'b0;
  assign INT_N_OE = irq_active;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] cur_sample;
  ssf_byte_t read_mux;
  always_comb
  begin
    cur_sample = sample_mem[sample_read_index];
    unique case (byte_sel)
      2'h0: read_mux = cur_sample[31:24];
      2'h1: read_mux = cur_sample[23:16];
      2'h2: read_mux = (MODE == SSF_MODE_PULSE) ? 8'h00 : cur_sample[15:8];
      2'h3: read_mux = (MODE == SSF_MODE_PULSE) ? 8'h00 : cur_sample[7:0];
    endcase
    if (ptr_over)
      read_mux = 8'h00;
    else if (reg_ptr == `SSF_ADDR_FLAGS)
      read_mux = irq_flags;
    else if (reg_ptr == `SSF_ADDR_MASK)
      read_mux = irq_mask;
    else if (reg_ptr == `SSF_ADDR_WR_IDX)
      read_mux = {4'h0, sample_write_index};
    else if (reg_ptr == `SSF_ADDR_LOST)
      read_mux = {4'h0, lost_sample_count};
    else if (reg_ptr == `SSF_ADDR_RD_IDX)
      read_mux = {4'h0, sample_read_index};
    else if (reg_ptr != `SSF_ADDR_DATA)
      read_mux = 8'h00;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      RD_DATA <= `SSF_REG_RESET;
      RD_VALID <= 1'b0;
    end
    else
    begin
      RD_VALID <= REG_RD;
      if (REG_RD)
        RD_DATA <= read_mux;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // every check lives in the system clock domain and sleeps during reset
  default clocking chk_clk @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  chk_flag_clear: assert property (
    (rd_flags && flag_set == 8'h00 && !POWER_SAVE) |=> irq_flags == 8'h00)
    else $error("flags not cleared by status read");
  chk_pin_masked: assert property (
    (irq_flags[`SSF_BIT_SUPPLY_OK] == 1'b0 && (irq_flags & irq_mask) == 8'h00)
    |-> !INT_N_OE)
    else $error("interrupt pin driven by masked flag");
  chk_supply_pin: assert property (
    (SUPPLY_OK && !POWER_SAVE) |=> INT_N_OE)
    else $error("supply flag did not drive the pin");
  chk_lost_sat: assert property (
    (lost_sample_count == `SSF_LOST_MAX && !wr_lost && !pop)
    |=> lost_sample_count == `SSF_LOST_MAX)
    else $error("lost count wrapped");
  chk_lost_pop: assert property (
    (pop && !wr_lost) |=> lost_sample_count == 4'h0)
    else $error("lost count not cleared on pop");
  chk_four_bytes: assert property (
    (rd_data && byte_sel == 2'h0 && !wr_ri) |=> $stable(sample_read_index))
    else $error("read index moved before four bytes");
  chk_data_addr: assert property (
    (rd_data && !ADDR_LOAD) |=> reg_ptr == `SSF_ADDR_DATA)
    else $error("address moved on data port read");
  chk_full_drop: assert property (
    (sample_in && buf_full && !wr_wi) |=> $stable(sample_write_index))
    else $error("sample stored while full");
  chk_save_clear: assert property (
    POWER_SAVE |=> irq_flags == 8'h00 && !INT_N_OE)
    else $error("flags survived power save");
  chk_pulse_zero: assert property (
    (rd_data && byte_sel[1] && MODE == SSF_MODE_PULSE) |=> RD_DATA == 8'h00)
    else $error("pulse mode red bytes not zero");

endmodule : ssf_top

// ### dv/ssf_host.sv
// host model: register port master standing in for the i2c controller
module ssf_host
  import ssf_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic [7:0] RD_DATA,
  input wire logic RD_VALID,
  output logic ADDR_LOAD,
  output logic [7:0] ADDR_IN,
  output logic REG_WR,
  output logic [7:0] WR_DATA,
  output logic REG_RD
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ADDR_LOAD = 1'b0;
    ADDR_IN = 8'h00;
    REG_WR = 1'b0;
    WR_DATA = 8'h00;
    REG_RD = 1'b0;
  end
  // released lines show the inverse, so a stale value is never trusted
  task automatic point(input ssf_byte_t a);
    @(posedge CLK_SYS);
    ADDR_LOAD <= 1'b1;
    ADDR_IN <= a;
    @(posedge CLK_SYS);
    ADDR_LOAD <= 1'b0;
    ADDR_IN <= ~a;
  endtask : point
  task automatic wr(input ssf_byte_t a, input ssf_byte_t d);
    point(a);
    REG_WR <= 1'b1;
    WR_DATA <= (a == 8'h01) ? (d & 8'hF0) : d;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
    WR_DATA <= ~d;
  endtask : wr
  task automatic rd(output ssf_byte_t d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1;
    while (RD_VALID !== 1'b1 && n < 4)
    begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end
    // a missing answer hands back unknowns so the caller's compare fails
    d = (RD_VALID === 1'b1) ? RD_DATA : 8'hXX;
  endtask : rd
endmodule : ssf_host

// ### dv/ssf_top_tb.sv
// self-checking bench of the sample fifo and its flags
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module ssf_top_tb
  import ssf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 1'b0;
  logic RESET = 1'b1;
  logic [2:0] MODE = 3'h0;
  logic POWER_SAVE = 1'b0;
  logic [1:0] ADC_RES = 2'h3;
  logic SAMPLE_VALID = 1'b0;
  logic [15:0] SAMPLE_IR = 16'h0000;
  logic [15:0] SAMPLE_RED = 16'h0000;
  logic TEMP_DONE = 1'b0;
  logic SUPPLY_OK = 1'b0;
  logic ADDR_LOAD, REG_WR, REG_RD, RD_VALID, INT_N_O, INT_N_OE;
  logic [7:0] ADDR_IN, WR_DATA, RD_DATA;
  int fail_count = 0;
  int total_checks = 0;
  ssf_byte_t b;
  always #5 CLK_SYS = ~CLK_SYS;
  ssf_top u_ssf_top (.CLK_SYS, .RESET, .MODE, .POWER_SAVE, .ADC_RES,
    .SAMPLE_VALID, .SAMPLE_IR, .SAMPLE_RED, .TEMP_DONE, .SUPPLY_OK,
    .ADDR_LOAD, .ADDR_IN, .REG_WR, .WR_DATA, .REG_RD, .RD_DATA,
    .RD_VALID, .INT_N_O, .INT_N_OE);
  ssf_host u_ssf_host (.CLK_SYS, .RD_DATA, .RD_VALID, .ADDR_LOAD,
    .ADDR_IN, .REG_WR, .WR_DATA, .REG_RD);
  // ----------------------------------------------------------------
  // stimulus helpers
  // ----------------------------------------------------------------
  task automatic peek(input ssf_byte_t a, output ssf_byte_t d);
    u_ssf_host.point(a);
    u_ssf_host.rd(d);
  endtask : peek
  task automatic push(input logic [15:0] ir, input logic [15:0] red);
    @(posedge CLK_SYS);
    SAMPLE_VALID <= 1'b1;
    SAMPLE_IR <= ir;
    SAMPLE_RED <= red;
    @(posedge CLK_SYS);
    SAMPLE_VALID <= 1'b0;
  endtask : push
  task automatic ev(input bit temp);
    @(posedge CLK_SYS);
    if (temp)
      TEMP_DONE <= 1'b1;
    else
      SUPPLY_OK <= 1'b1;
    @(posedge CLK_SYS);
    TEMP_DONE <= 1'b0;
    SUPPLY_OK <= 1'b0;
    #1;
  endtask : ev
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    u_ssf_host.point(8'h00);
    for (int i = 0; i < 5; i++)
    begin
      u_ssf_host.rd(b);
      `CHK(b, 8'h00)
    end
    `CHK(INT_N_OE, 1'b0)
    ev(1'b0);
    `CHK(INT_N_OE, 1'b1)
    `CHK(INT_N_O, 1'b0)
    u_ssf_host.point(8'hFF);
    u_ssf_host.rd(b);
    u_ssf_host.rd(b);
    `CHK(b, 8'h00)
    peek(8'h00, b);
    `CHK(b, 8'h01)
    @(posedge CLK_SYS);
    #1;
    `CHK(INT_N_OE, 1'b0)
  endtask : t_regs
  task automatic t_fifo;
    logic [7:0] exp [8] = '{8'h12, 8'h34, 8'h56, 8'h78,
                            8'h9A, 8'hBC, 8'hDE, 8'hF0};
    logic [7:0] jst [8] = '{8'hAA, 8'hA8, 8'h00, 8'h00,
                            8'h80, 8'h02, 8'h00, 8'h00};
    @(posedge CLK_SYS);
    MODE <= SSF_MODE_OXY;
    push(16'h1234, 16'h5678);
    push(16'h9ABC, 16'hDEF0);
    peek(8'h00, b);
    `CHK(b, 8'h30)
    peek(8'h00, b);
    `CHK(b, 8'h00)
    u_ssf_host.point(8'h05);
    for (int i = 0; i < 8; i++)
    begin
      u_ssf_host.rd(b);
      `CHK(b, exp[i])
    end
    peek(8'h04, b);
    `CHK(b, 8'h02)
    u_ssf_host.wr(8'h04, 8'h01);
    peek(8'h05, b);
    `CHK(b, 8'h9A)
    @(posedge CLK_SYS);
    MODE <= SSF_MODE_PULSE;
    ADC_RES <= 2'h0;
    push(16'h0155, 16'h0AAA);
    peek(8'h00, b);
    `CHK(b, 8'h20)
    u_ssf_host.wr(8'h04, 8'h02);
    u_ssf_host.point(8'h05);
    for (int i = 0; i < 4; i++)
    begin
      u_ssf_host.rd(b);
      `CHK(b, (i == 0) ? 8'h0A : (i == 1) ? 8'hA8 : 8'h00)
    end
    // 14-bit and 15-bit words must also land with the msb at bit 15
    @(posedge CLK_SYS);
    ADC_RES <= 2'h1;
    push(16'h2AAA, 16'h0000);
    @(posedge CLK_SYS);
    ADC_RES <= 2'h2;
    push(16'h4001, 16'h0000);
    u_ssf_host.point(8'h05);
    for (int i = 0; i < 8; i++)
    begin
      u_ssf_host.rd(b);
      `CHK(b, jst[i])
    end
    peek(8'h00, b);
    `CHK(b, 8'h00)
  endtask : t_fifo
  task automatic t_full;
    @(posedge CLK_SYS);
    MODE <= SSF_MODE_OXY;
    ADC_RES <= 2'h3;
    u_ssf_host.wr(8'h02, 8'h00);
    u_ssf_host.wr(8'h03, 8'h00);
    u_ssf_host.wr(8'h04, 8'h00);
    peek(8'h00, b);
    for (int i = 0; i < 14; i++)
      push(16'(i), ~16'(i));
    peek(8'h00, b);
    `CHK(b, 8'h30)
    push(16'h000E, 16'hFFF1);
    peek(8'h00, b);
    `CHK(b, 8'hB0)
    push(16'h000F, 16'hFFF0);
    peek(8'h02, b);
    `CHK(b, 8'h00)
    for (int i = 0; i < 17; i++)
      push(16'hAAAA, 16'h5555);
    peek(8'h03, b);
    `CHK(b, 8'h0F)
    peek(8'h02, b);
    `CHK(b, 8'h00)
    u_ssf_host.point(8'h05);
    for (int i = 0; i < 4; i++)
    begin
      u_ssf_host.rd(b);
      `CHK(b, (i < 2) ? 8'h00 : 8'hFF)
    end
    peek(8'h03, b);
    `CHK(b, 8'h00)
  endtask : t_full
  task automatic t_irq;
    @(posedge CLK_SYS);
    MODE <= 3'h0;
    u_ssf_host.wr(8'h01, 8'h00);
    peek(8'h00, b);
    ev(1'b1);
    `CHK(INT_N_OE, 1'b0)
    peek(8'h00, b);
    `CHK(b, 8'h40)
    u_ssf_host.wr(8'h01, 8'h40);
    ev(1'b1);
    `CHK(INT_N_OE, 1'b1)
    @(posedge CLK_SYS);
    POWER_SAVE <= 1'b1;
    ev(1'b1);
    peek(8'h00, b);
    `CHK(b, 8'h00)
    peek(8'h01, b);
    `CHK(b, 8'h40)
    @(posedge CLK_SYS);
    POWER_SAVE <= 1'b0;
    u_ssf_host.wr(8'h02, 8'h05);
    peek(8'h02, b);
    `CHK(b, 8'h00)
    @(posedge CLK_SYS);
    MODE <= SSF_MODE_PULSE;
    u_ssf_host.wr(8'h02, 8'h05);
    peek(8'h02, b);
    `CHK(b, 8'h05)
    @(posedge CLK_SYS);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RESET <= 1'b0;
    peek(8'h01, b);
    `CHK(b, 8'h00)
  endtask : t_irq
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    #400000;
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (6) @(posedge CLK_SYS);
    RESET <= 1'b0;
    t_regs();
    t_fifo();
    t_full();
    t_irq();
    print_verdict();
  end
endmodule : ssf_top_tb
